// [amp_pin_pkg.sv]
// Shared types and constants for the amplifier fault and warning pin logic
package amp_pin_pkg;

   // Clock rate and derived timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int RAMP_TIME_US  = 5000;
   localparam int RAMP_CYC      = RAMP_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int PWM_DIV_CYC   = 12;

   // Reset values
   localparam logic [7:0] CLIP_WIN_RST = 8'h14;
   localparam logic [1:0] HEAT_SEL_RST = 2'h0;

   // Fault detector levels
   typedef struct packed {
      logic ocp;
      logic dc_off;
      logic heat_trip;
      logic low_batt;
      logic low_out;
      logic high_batt;
      logic high_out;
      logic clk_err;
   } fault_s;

   // Warning status bits
   typedef struct packed {
      logic clip;
      logic heat_alert;
      logic clamp;
      logic powerup;
   } warn_s;

   // Inputs that arrive from outside the clock domain
   typedef struct packed {
      fault_s flt;
      logic   heat_glob;
      logic   heat_chan;
      logic   clamp;
      logic   pwm_full;
      logic   silence_n;
      logic   sleep_n;
   } pins_s;

   // Per-category masks onto the fault pin
   typedef struct packed {
      logic chan;
      logic thermal;
      logic voltage;
      logic clock;
   } fault_mask_s;

   // Per-source masks onto the warning pin
   typedef struct packed {
      logic clip;
      logic heat;
      logic clamp;
   } warn_mask_s;

   // Operating states
   typedef enum logic [2:0] {
      ST_STANDBY = 3'b000,
      ST_HIZ     = 3'b001,
      ST_MUTE    = 3'b010,
      ST_PLAY    = 3'b011,
      ST_RAMP    = 3'b100
   } op_state_e;

endpackage

// [amp_fault_warn_pin_control.sv]
// Fault and warning pin latches, clip detection and operating state control
//
// Overview of operation
// - Any fault drives error_out_n low
// - Error pin latched until sticky clear
// - Heat trip pin releases on auto-recovery
// - Fault status bits sticky until sticky clear
// - Fault masks gate only the pin
// - Clip, heat, clamp, powerup drive alert_out_n
// - Clip after programmable run of full PWM
// - Latching clip status sticky until clear
// - Heat alert from global or channel warning
// - Warning masks gate only the pin
// - Alert pin latched until sticky clear
// - silence_n low mutes the channel
// - sleep_n low ramps down within 5 ms
// - Standby, Hi-Z, mute and play states
// - Global and channel faults both force Hi-Z
// - Non-latching clip follows full duty live
// - Current clamp warns, never faults
`timescale 1ns/1ps
module amp_fault_warn_pin_control
   import amp_pin_pkg::*;
#(
   parameter int RAMP_CYCLES = RAMP_CYC
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        srst,
   // Detector levels and pins, asynchronous
   input  wire pins_s       pins_async,
   // Control bits from the register logic
   input  wire logic        sticky_clear_cmd,
   input  wire fault_mask_s fault_mask,
   input  wire warn_mask_s  warn_mask,
   input  wire logic [7:0]  clip_window,
   input  wire logic        clip_nonlatch,
   input  wire logic        auto_recover_en,
   input  wire logic [1:0]  heat_sel,
   input  wire op_state_e   state_req,
   // Open-drain status pins
   output logic             error_out_n_o,
   output logic             error_out_n_oe_n,
   output logic             alert_out_n_o,
   output logic             alert_out_n_oe_n,
   // Status and stage control
   output fault_s           fault_status,
   output warn_s            warn_status,
   output op_state_e        op_state,
   output logic             osc_run,
   output logic             stage_hiz,
   output logic             stage_duty50,
   output logic [1:0]       heat_thresh
);

   // Synchroniser stages
   pins_s       sync1_reg;
   pins_s       p;
   // Clip detection
   logic [3:0]  pwm_div_reg, pwm_div_next;
   logic [7:0]  clip_run_reg, clip_run_next;
   logic        pwm_tick;
   logic        clip_hit;
   logic        clip_evt;
   // Latches
   fault_s      fault_next;
   warn_s       warn_next;
   logic        err_latch_reg, err_latch_next;
   logic        therm_hold_reg, therm_hold_next;
   logic        alert_latch_reg, alert_latch_next;
   logic        pup_reg;
   logic        chan_f, volt_f, heat_any, hold_hiz;
   // State machine
   op_state_e   state_next;
   logic [16:0] ramp_cnt_reg, ramp_cnt_next;

   // Active target for a running channel, mute pin overrides play
   function automatic op_state_e run_target(input op_state_e req, input logic sil_n);
      if (req == ST_PLAY && !sil_n)
         return ST_MUTE;
      return req;
   endfunction

   // Two-stage synchroniser; only the second stage is read
   always_ff @(posedge mclk) begin
      if (srst) begin
         sync1_reg <= '0;
         p         <= '0;
      end else begin
         sync1_reg <= pins_async;
         p         <= sync1_reg;
      end
   end

   // PWM clock enable and full-modulation run counter
   always_comb begin
      pwm_tick      = (pwm_div_reg == 4'(PWM_DIV_CYC - 1));
      pwm_div_next  = pwm_tick ? 4'h0 : pwm_div_reg + 4'h1;
      clip_run_next = clip_run_reg;
      if (pwm_tick) begin
         if (!p.pwm_full)
            clip_run_next = 8'h00;
         else if (clip_run_reg != 8'hFF)
            clip_run_next = clip_run_reg + 8'h01;
      end
      // Window of zero would report every full cycle; treat as one
      clip_hit = p.pwm_full && (clip_run_reg >= clip_window) && (clip_run_reg != 8'h00);
      clip_evt = clip_nonlatch ? p.pwm_full : clip_hit;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         pwm_div_reg  <= 4'h0;
         clip_run_reg <= 8'h00;
      end else begin
         pwm_div_reg  <= pwm_div_next;
         clip_run_reg <= clip_run_next;
      end
   end

   // Sticky status, pin latches; a set in the clear cycle wins
   always_comb begin
      chan_f   = p.flt.ocp | p.flt.dc_off;
      volt_f   = p.flt.low_batt | p.flt.low_out | p.flt.high_batt | p.flt.high_out;
      heat_any = p.heat_glob | p.heat_chan;
      fault_next = (sticky_clear_cmd ? '0 : fault_status) | p.flt;
      warn_next.clip = clip_nonlatch ? p.pwm_full
                     : ((!sticky_clear_cmd & warn_status.clip) | clip_hit);
      warn_next.heat_alert = (!sticky_clear_cmd & warn_status.heat_alert) | heat_any;
      warn_next.clamp      = (!sticky_clear_cmd & warn_status.clamp) | p.clamp;
      warn_next.powerup    = (!sticky_clear_cmd & warn_status.powerup) | pup_reg;
      // fault sources, masks gate pin only, clamp excluded
      err_latch_next = (!sticky_clear_cmd & err_latch_reg)
                     | (chan_f & !fault_mask.chan)
                     | (volt_f & !fault_mask.voltage)
                     | (p.flt.clk_err & !fault_mask.clock);
      therm_hold_next = (!(sticky_clear_cmd | (auto_recover_en & !p.flt.heat_trip))
                         & therm_hold_reg) | p.flt.heat_trip;
      // warning sources, masks gate pin only, latched
      alert_latch_next = (!sticky_clear_cmd & alert_latch_reg)
                       | (clip_evt & !warn_mask.clip)
                       | (heat_any & !warn_mask.heat)
                       | (p.clamp & !warn_mask.clamp)
                       | pup_reg;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         fault_status     <= '0;
         warn_status      <= '0;
         err_latch_reg    <= 1'b0;
         therm_hold_reg   <= 1'b0;
         alert_latch_reg  <= 1'b0;
         pup_reg          <= 1'b1;
         error_out_n_o    <= 1'b0;
         alert_out_n_o    <= 1'b0;
         error_out_n_oe_n <= 1'b1;
         alert_out_n_oe_n <= 1'b1;
         heat_thresh      <= HEAT_SEL_RST;
      end else begin
         fault_status     <= fault_next;
         warn_status      <= warn_next;
         err_latch_reg    <= err_latch_next;
         therm_hold_reg   <= therm_hold_next;
         alert_latch_reg  <= alert_latch_next;
         pup_reg          <= 1'b0;
         error_out_n_o    <= 1'b0;
         alert_out_n_o    <= 1'b0;
         // pin follows latch; enable low pulls the wire low
         error_out_n_oe_n <= !(err_latch_next | (therm_hold_next & !fault_mask.thermal));
         alert_out_n_oe_n <= !alert_latch_next;
         heat_thresh      <= heat_sel;
      end
   end

   // Operating state; protective action ignores all masks
   always_comb begin
      hold_hiz = ((fault_next & ~fault_s'(8'h20)) != '0) | therm_hold_next;
      state_next    = op_state;
      ramp_cnt_next = 17'h0_0000;
      unique case (op_state)
         ST_STANDBY: begin
            // Leave only when asked to; otherwise standby and Hi-Z would alternate
            if (p.sleep_n && state_req != ST_STANDBY)
               state_next = ST_HIZ;
         end
         ST_HIZ: begin
            if (!p.sleep_n || state_req == ST_STANDBY)
               state_next = ST_STANDBY;
            else if (!hold_hiz)
               state_next = run_target(state_req, p.silence_n);
         end
         ST_MUTE,
         ST_PLAY: begin
            if (!p.sleep_n || state_req == ST_STANDBY)
               state_next = ST_RAMP;
            else if (hold_hiz)
               state_next = ST_HIZ;
            else
               state_next = run_target(state_req, p.silence_n);
         end
         ST_RAMP: begin
            ramp_cnt_next = ramp_cnt_reg + 17'h0_0001;
            // ramp bounded, fault cuts it short
            if (hold_hiz || ramp_cnt_reg == 17'(RAMP_CYCLES - 1))
               state_next = ST_STANDBY;
         end
         default: state_next = ST_STANDBY;
      endcase
   end

   // State register and stage controls decoded ahead of the flop
   always_ff @(posedge mclk) begin
      if (srst) begin
         op_state     <= ST_STANDBY;
         ramp_cnt_reg <= 17'h0_0000;
         osc_run      <= 1'b0;
         stage_hiz    <= 1'b1;
         stage_duty50 <= 1'b0;
      end else begin
         op_state     <= state_next;
         ramp_cnt_reg <= ramp_cnt_next;
         osc_run      <= (state_next != ST_STANDBY);
         stage_hiz    <= (state_next == ST_STANDBY) || (state_next == ST_HIZ);
         stage_duty50 <= (state_next == ST_MUTE);
      end
   end

   // Checks on pin, status and state behaviour
   err_fault_a: assert property (@(posedge mclk) disable iff (srst)
      (p.flt.ocp && !fault_mask.chan) |=> !error_out_n_oe_n)
      else $error("overcurrent did not pull the fault pin");
   err_hold_a: assert property (@(posedge mclk) disable iff (srst)
      (!error_out_n_oe_n && !sticky_clear_cmd && !auto_recover_en) |=> !error_out_n_oe_n)
      else $error("fault pin released without clear");
   heat_auto_a: assert property (@(posedge mclk) disable iff (srst)
      (therm_hold_reg && auto_recover_en && !p.flt.heat_trip) |=> !therm_hold_reg)
      else $error("heat trip hold did not auto-release");
   fault_sticky_a: assert property (@(posedge mclk) disable iff (srst)
      (fault_status.dc_off && !sticky_clear_cmd) |=> fault_status.dc_off ##1 1'b1)
      else $error("fault status dropped without clear");
   mask_status_a: assert property (@(posedge mclk) disable iff (srst)
      (p.flt.clk_err && fault_mask.clock) |=> fault_status.clk_err)
      else $error("masked fault missing from status");
   alert_pup_a: assert property (@(posedge mclk)
      $fell(srst) |=> (!alert_out_n_oe_n && warn_status.powerup))
      else $error("powerup event not reported");
   clip_run_a: assert property (@(posedge mclk) disable iff (srst)
      (clip_hit && !clip_nonlatch && !warn_mask.clip) |=> !alert_out_n_oe_n && warn_status.clip)
      else $error("clip run not reported");
   clip_live_a: assert property (@(posedge mclk) disable iff (srst)
      clip_nonlatch |=> (warn_status.clip == $past(p.pwm_full)) || !clip_nonlatch)
      else $error("non-latching clip not live");
   alert_hold_a: assert property (@(posedge mclk) disable iff (srst)
      (!alert_out_n_oe_n && !sticky_clear_cmd) |=> !alert_out_n_oe_n)
      else $error("alert pin released without clear");
   clamp_nofault_a: assert property (@(posedge mclk) disable iff (srst)
      (p.flt == '0 && !err_latch_reg && !therm_hold_reg) |=> error_out_n_oe_n)
      else $error("fault pin low without fault");
   sleep_ramp_a: assert property (@(posedge mclk) disable iff (srst)
      (op_state == ST_RAMP) |-> (ramp_cnt_reg < 17'(RAMP_CYCLES)))
      else $error("ramp down overran its limit");
   ramp_exit_a: assert property (@(posedge mclk) disable iff (srst)
      (op_state == ST_RAMP && ramp_cnt_reg == 17'(RAMP_CYCLES - 1)) |=> op_state == ST_STANDBY)
      else $error("ramp down did not end in standby");
   heat_warn_a: assert property (@(posedge mclk) disable iff (srst)
      p.heat_chan |=> warn_status.heat_alert)
      else $error("channel heat warning not reported");
   warn_mask_a: assert property (@(posedge mclk) disable iff (srst)
      (p.clamp && warn_mask.clamp) |=> warn_status.clamp)
      else $error("masked clamp missing from status");
   clear_all_a: assert property (@(posedge mclk) disable iff (srst)
      (sticky_clear_cmd && p.flt == '0) |=> (fault_status == '0))
      else $error("sticky clear left fault status set");
   stage_map_a: assert property (@(posedge mclk) disable iff (srst)
      (op_state == ST_MUTE) |-> (osc_run && !stage_hiz && stage_duty50))
      else $error("mute state stage controls wrong");
   fault_hiz_a: assert property (@(posedge mclk) disable iff (srst)
      (op_state == ST_PLAY && p.flt.dc_off && p.sleep_n && state_req != ST_STANDBY)
      |=> op_state == ST_HIZ)
      else $error("channel fault did not force Hi-Z");
   mute_pin_a: assert property (@(posedge mclk) disable iff (srst)
      (op_state == ST_PLAY && !p.silence_n && p.sleep_n && !hold_hiz
       && state_req == ST_PLAY) |=> op_state == ST_MUTE)
      else $error("mute pin ignored");

endmodule // amp_fault_warn_pin_control

// [amp_host_model.sv]
// Host and supply controller model driving the amplifier control pins
`timescale 1ns/1ps
module amp_host_model
   import amp_pin_pkg::*;
#(
   parameter int HOLD_CYC = 8
) (
   // Clock and reset
   input  wire logic  mclk,
   input  wire logic  srst,
   // Requests from the bench
   input  wire pins_s drv,
   input  wire logic  sleep_req,
   // Open-drain pins from the device
   input  wire logic  error_out_n_o,
   input  wire logic  error_out_n_oe_n,
   input  wire logic  alert_out_n_o,
   input  wire logic  alert_out_n_oe_n,
   // Resolved levels
   output pins_s      pins,
   output logic       error_pin,
   output logic       alert_pin,
   output logic [2:0] rails
);
   logic [7:0] hold_cnt;

   // Pull-up wins while the device releases the pin
   assign error_pin = error_out_n_oe_n ? 1'b1 : error_out_n_o;
   assign alert_pin = alert_out_n_oe_n ? 1'b1 : alert_out_n_o;

   always_comb begin
      pins         = drv;
      pins.sleep_n = sleep_req & (&rails);
   end

   // rail bring-up order
   // Battery first, logic second, output stage last; rails drop only after hold
   always_ff @(posedge mclk) begin
      if (srst) begin
         rails    <= 3'h0;
         hold_cnt <= 8'h00;
      end else if (!sleep_req) begin
         if (hold_cnt < 8'(HOLD_CYC))
            hold_cnt <= hold_cnt + 8'h01;
         else
            rails <= 3'h0;
      end else begin
         hold_cnt <= 8'h00;
         rails    <= {rails[1:0], 1'b1};
      end
   end
endmodule // amp_host_model

// [test_amp_fault_warn_pin_control.sv]
// Self-checking bench for the fault and warning pin logic
`timescale 1ns/1ps
module test_amp_fault_warn_pin_control;
   import amp_pin_pkg::*;
   localparam int RAMP_SIM = 20;
   logic mclk = 1'b0, srst = 1'b1, sleep_req = 1'b1, sticky_clear_cmd = 1'b0;
   logic clip_nonlatch = 1'b0, auto_recover_en = 1'b0;
   logic [7:0] clip_window = 8'h14;
   logic [1:0] heat_sel = 2'h0, heat_thresh;
   logic error_o, error_oe_n, alert_o, alert_oe_n, error_pin, alert_pin, osc_run;
   logic stage_hiz, stage_duty50;
   logic [2:0] rails;
   pins_s drv, pins;
   fault_mask_s fault_mask = '0;
   warn_mask_s warn_mask = '0;
   fault_s fault_status;
   warn_s warn_status;
   op_state_e op_state;
   op_state_e state_req = ST_PLAY;
   int fail_count = 0, tests_run = 0, i;

   // Clock at 25 MHz
   always #20 mclk = ~mclk;

   amp_fault_warn_pin_control #(.RAMP_CYCLES(RAMP_SIM)) i_amp_fault_warn_pin_control (
      .mclk(mclk), .srst(srst), .pins_async(pins), .sticky_clear_cmd(sticky_clear_cmd),
      .fault_mask(fault_mask), .warn_mask(warn_mask), .clip_window(clip_window),
      .clip_nonlatch(clip_nonlatch), .auto_recover_en(auto_recover_en), .heat_sel(heat_sel),
      .state_req(state_req), .error_out_n_o(error_o), .error_out_n_oe_n(error_oe_n),
      .alert_out_n_o(alert_o), .alert_out_n_oe_n(alert_oe_n), .fault_status(fault_status),
      .warn_status(warn_status), .op_state(op_state), .osc_run(osc_run),
      .stage_hiz(stage_hiz), .stage_duty50(stage_duty50), .heat_thresh(heat_thresh));

   amp_host_model i_amp_host_model (
      .mclk(mclk), .srst(srst), .drv(drv), .sleep_req(sleep_req),
      .error_out_n_o(error_o), .error_out_n_oe_n(error_oe_n), .alert_out_n_o(alert_o),
      .alert_out_n_oe_n(alert_oe_n), .pins(pins), .error_pin(error_pin),
      .alert_pin(alert_pin), .rails(rails));

   // Inputs change only at falling edges
   task automatic step(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One-cycle clear pulse, then let its edge land
   task automatic clr;
      sticky_clear_cmd = 1'b1;
      step(1);
      sticky_clear_cmd = 1'b0;
      step(1);
   endtask

   task automatic test_done;
      $display("Checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Watchdog sized well beyond the whole sequence
   initial begin
      repeat (6000) @(posedge mclk);
      fail_count++;
      test_done;
   end

   // Main sequence
   initial begin
      drv = '0;
      drv.silence_n = 1'b1;
      step(16);
      srst = 1'b0;
      step(2);
      check("alert_pin", alert_pin, 1'b0);
      check("error_pin", error_pin, 1'b1);
      check("warn_status", warn_status, 8'h01);
      clr;
      check("alert_pin", alert_pin, 1'b1);
      step(10);
      check("op_state", op_state, ST_PLAY);
      check("stage", {osc_run, stage_hiz, stage_duty50}, 8'h04);
      $display("test power_up done");
      // Every fault source latches the pin and the status bit
      for (i = 0; i < 8; i++) begin
         drv.flt = fault_s'(8'h80 >> i);
         step(5);
         check("error_pin", error_pin, 1'b0);
         check("stage_hiz", stage_hiz, 1'b1);
         drv.flt = '0;
         step(5);
         check("error_pin", error_pin, 1'b0);
         check("fault_status", fault_status, 8'h80 >> i);
         clr;
         check("error_pin", error_pin, 1'b1);
         check("fault_status", fault_status, 8'h00);
         step(8);
         check("op_state", op_state, ST_PLAY);
      end
      $display("test faults done");
      auto_recover_en = 1'b1;
      drv.flt.heat_trip = 1'b1;
      step(5);
      check("error_pin", error_pin, 1'b0);
      drv.flt.heat_trip = 1'b0;
      step(5);
      check("error_pin", error_pin, 1'b1);
      check("fault_status", fault_status, 8'h20);
      clr;
      auto_recover_en = 1'b0;
      fault_mask = '1;
      drv.flt.ocp = 1'b1;
      drv.flt.clk_err = 1'b1;
      step(5);
      check("error_pin", error_pin, 1'b1);
      check("fault_status", fault_status, 8'h81);
      check("stage_hiz", stage_hiz, 1'b1);
      drv.flt = '0;
      fault_mask = '0;
      drv.flt.dc_off = 1'b1;
      step(5);
      clr;
      check("error_pin", error_pin, 1'b0);
      check("fault_status", fault_status, 8'h40);
      drv.flt = '0;
      step(4);
      clr;
      $display("test recovery_mask done");
      // Warning sources: global heat, channel heat, current clamp
      for (i = 0; i < 3; i++) begin
         {drv.heat_glob, drv.heat_chan, drv.clamp} = 3'h4 >> i;
         step(5);
         check("alert_pin", alert_pin, 1'b0);
         check("error_pin", error_pin, 1'b1);
         {drv.heat_glob, drv.heat_chan, drv.clamp} = 3'h0;
         step(5);
         check("alert_pin", alert_pin, 1'b0);
         check("warn_status", warn_status, (i == 2) ? 8'h02 : 8'h04);
         clr;
      end
      warn_mask = '1;
      {drv.heat_glob, drv.clamp} = 2'h3;
      step(5);
      check("alert_pin", alert_pin, 1'b1);
      check("warn_status", warn_status, 8'h06);
      {drv.heat_glob, drv.clamp} = 2'h0;
      warn_mask = '0;
      step(4);
      clr;
      for (i = 0; i < 4; i++) begin
         heat_sel = 2'(i);
         step(2);
         check("heat_thresh", heat_thresh, 8'(i));
      end
      $display("test warnings done");
      // Clip run of three PWM clocks, latching then live
      clip_window = 8'h03;
      drv.pwm_full = 1'b1;
      step(14);
      check("clip", warn_status.clip, 1'b0);
      step(30);
      check("clip", warn_status.clip, 1'b1);
      check("alert_pin", alert_pin, 1'b0);
      drv.pwm_full = 1'b0;
      step(5);
      check("clip", warn_status.clip, 1'b1);
      clr;
      check("clip", warn_status.clip, 1'b0);
      clip_nonlatch = 1'b1;
      drv.pwm_full = 1'b1;
      step(44);
      check("clip", warn_status.clip, 1'b1);
      drv.pwm_full = 1'b0;
      step(5);
      check("clip", warn_status.clip, 1'b0);
      clip_nonlatch = 1'b0;
      clr;
      $display("test clip done");
      drv.silence_n = 1'b0;
      step(6);
      check("op_state", op_state, ST_MUTE);
      check("stage_duty50", stage_duty50, 1'b1);
      drv.silence_n = 1'b1;
      step(6);
      check("op_state", op_state, ST_PLAY);
      sleep_req = 1'b0;
      step(6);
      check("op_state", op_state, ST_RAMP);
      step(RAMP_SIM + 4);
      check("op_state", op_state, ST_STANDBY);
      check("stage", {osc_run, stage_hiz}, 8'h01);
      sleep_req = 1'b1;
      step(14);
      check("op_state", op_state, ST_PLAY);
      // Requested states through the state control bits
      state_req = ST_HIZ;
      step(2);
      check("op_state", op_state, ST_HIZ);
      check("stage", {osc_run, stage_hiz, stage_duty50}, 8'h06);
      state_req = ST_STANDBY;
      step(2);
      check("op_state", op_state, ST_STANDBY);
      state_req = ST_MUTE;
      step(3);
      check("op_state", op_state, ST_MUTE);
      state_req = ST_PLAY;
      step(2);
      check("op_state", op_state, ST_PLAY);
      $display("test states done");
      test_done;
   end
endmodule // test_amp_fault_warn_pin_control
